/* clk_switch_pkg.sv */
// constants shared by the dual oscillator clock switch: register map,
// field positions, reset values, wait counts and the source encoding.
// assumes a classic wishbone slave with 32-bit data and byte addresses.
package clk_switch_pkg;

	// ****************************************************************
	// register map: printed offsets are indices, byte address is 4x
	// ****************************************************************
	localparam logic [15:0] SRC_IDX = 16'h5060;
	localparam logic [15:0] CTL_IDX = 16'h5061;
	localparam logic [15:0] STAT_IDX = 16'h5068;
	localparam logic [31:0] SRC_ADDR = {14'h0000, SRC_IDX, 2'b00};
	localparam logic [31:0] CTL_ADDR = {14'h0000, CTL_IDX, 2'b00};
	localparam logic [31:0] STAT_ADDR = {14'h0000, STAT_IDX, 2'b00};

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int MAIN_EN_BIT = 0;
	localparam int SUB_EN_BIT = 1;
	localparam int WAIT_LSB = 4;
	localparam int WAIT_MSB = 5;
	localparam int SRC_BIT = 0;
	localparam int ST_MAIN_VALID = 0;
	localparam int ST_SUB_VALID = 1;
	localparam int ST_ACTIVE = 2;
	localparam int ST_CORE_RUN = 3;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [7:0] CTL_RST = 8'h01;
	localparam logic [7:0] SRC_RST = 8'h00;

	// ****************************************************************
	// stabilisation counts, stored as terminal value (count - 1)
	// ****************************************************************
	localparam int CNT_W = 10;
	localparam logic [CNT_W-1:0] MAIN_TERM_128 = 10'h07F;
	localparam logic [CNT_W-1:0] MAIN_TERM_256 = 10'h0FF;
	localparam logic [CNT_W-1:0] MAIN_TERM_512 = 10'h1FF;
	localparam logic [CNT_W-1:0] MAIN_TERM_1024 = 10'h3FF;
	localparam logic [CNT_W-1:0] SUB_TERM_256 = 10'h0FF;

	// system clock source
	typedef enum logic {
		SRC_MAIN = 1'b0,
		SRC_SUB = 1'b1
	} src_t;

endpackage : clk_switch_pkg

/* dual_oscillator_clock_switch.sv */
// dual oscillator enable, stabilisation wait and glitch-free system clock
// switch, with its registers on a classic wishbone slave.
// assumes oscillator outputs arrive as levels synchronous to core_clk_i
// and that software follows the documented switching sequences.
`timescale 1ns/1ps

module dual_oscillator_clock_switch (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic sleep_i,
	input wire logic main_osc_clk_i,
	input wire logic sub_osc_clk_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic main_osc_run_o,
	output logic sub_osc_run_o,
	output logic sysclk_o,
	output logic sysclk_src_o,
	output logic core_run_o
);

	// ****************************************************************
	// state
	// ****************************************************************
	logic [7:0] ctl_q, ctl_d;
	logic [7:0] src_q, src_d;
	logic [31:0] dat_q, dat_d;
	logic ack_q, ack_d;
	logic main_run_q, main_run_d;
	logic sub_run_q, sub_run_d;
	logic main_prev_q, main_prev_d;
	logic sub_prev_q, sub_prev_d;
	logic [clk_switch_pkg::CNT_W-1:0] main_cnt_q, main_cnt_d;
	logic [clk_switch_pkg::CNT_W-1:0] sub_cnt_q, sub_cnt_d;
	logic main_valid_q, main_valid_d;
	logic sub_valid_q, sub_valid_d;
	clk_switch_pkg::src_t active_q, active_d;
	logic sys_q, sys_d;
	logic core_run_q, core_run_d;

	logic bus_hit;
	logic [clk_switch_pkg::CNT_W-1:0] main_term;
	clk_switch_pkg::src_t target;
	logic tgt_valid, tgt_lvl, act_valid, act_lvl;

	// wait code to terminal count; code 0 is the longest wait
	function automatic logic [clk_switch_pkg::CNT_W-1:0] wait_term(input logic [1:0] code);
		case (code)
			2'h3: wait_term = clk_switch_pkg::MAIN_TERM_128;
			2'h2: wait_term = clk_switch_pkg::MAIN_TERM_256;
			2'h1: wait_term = clk_switch_pkg::MAIN_TERM_512;
			default: wait_term = clk_switch_pkg::MAIN_TERM_1024;
		endcase
	endfunction : wait_term

	// ****************************************************************
	// register bus
	// ****************************************************************
	// one wait state: ack follows the request, then drops for a cycle
	always_comb
	begin
		bus_hit = wb_cyc_i && wb_stb_i && !ack_q;
		ack_d = bus_hit;
		ctl_d = ctl_q;
		src_d = src_q;
		dat_d = 32'h0000_0000;
		if (bus_hit && wb_we_i && wb_sel_i[0])
		begin
			// reserved bits are dropped so they read back as zero
			if (wb_adr_i[31:2] == clk_switch_pkg::CTL_ADDR[31:2])
			begin
				ctl_d = 8'h00;
				ctl_d[clk_switch_pkg::MAIN_EN_BIT] = wb_dat_i[clk_switch_pkg::MAIN_EN_BIT];
				ctl_d[clk_switch_pkg::SUB_EN_BIT] = wb_dat_i[clk_switch_pkg::SUB_EN_BIT];
				ctl_d[clk_switch_pkg::WAIT_MSB:clk_switch_pkg::WAIT_LSB] =
					wb_dat_i[clk_switch_pkg::WAIT_MSB:clk_switch_pkg::WAIT_LSB];
			end
			if (wb_adr_i[31:2] == clk_switch_pkg::SRC_ADDR[31:2])
			begin
				src_d = 8'h00;
				src_d[clk_switch_pkg::SRC_BIT] = wb_dat_i[clk_switch_pkg::SRC_BIT];
			end
		end
		if (bus_hit && !wb_we_i)
		begin
			// unmapped addresses are acked and read as zero
			if (wb_adr_i[31:2] == clk_switch_pkg::CTL_ADDR[31:2])
				dat_d[7:0] = ctl_q;
			else if (wb_adr_i[31:2] == clk_switch_pkg::SRC_ADDR[31:2])
				dat_d[7:0] = src_q;
			else if (wb_adr_i[31:2] == clk_switch_pkg::STAT_ADDR[31:2])
			begin
				dat_d[clk_switch_pkg::ST_MAIN_VALID] = main_valid_q;
				dat_d[clk_switch_pkg::ST_SUB_VALID] = sub_valid_q;
				dat_d[clk_switch_pkg::ST_ACTIVE] = active_q;
				dat_d[clk_switch_pkg::ST_CORE_RUN] = core_run_q;
			end
		end
	end

	// bus registers
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			ctl_q <= clk_switch_pkg::CTL_RST;
			src_q <= clk_switch_pkg::SRC_RST;
			dat_q <= 32'h0000_0000;
			ack_q <= 1'b0;
		end
		else
		begin
			ctl_q <= ctl_d;
			src_q <= src_d;
			dat_q <= dat_d;
			ack_q <= ack_d;
		end
	end

	// ****************************************************************
	// oscillator enables and stabilisation counters
	// ****************************************************************
	// a selected source stays running even if its enable bit is clear,
	// so a careless write cannot pull the clock out from under the core
	always_comb
	begin
		main_term = wait_term(ctl_q[clk_switch_pkg::WAIT_MSB:clk_switch_pkg::WAIT_LSB]);
		main_run_d = !sleep_i && (ctl_q[clk_switch_pkg::MAIN_EN_BIT] ||
			active_q == clk_switch_pkg::SRC_MAIN);
		sub_run_d = !sleep_i && (ctl_q[clk_switch_pkg::SUB_EN_BIT] ||
			active_q == clk_switch_pkg::SRC_SUB);
		main_prev_d = main_osc_clk_i;
		sub_prev_d = sub_osc_clk_i;
		main_cnt_d = main_cnt_q;
		main_valid_d = main_valid_q;
		sub_cnt_d = sub_cnt_q;
		sub_valid_d = sub_valid_q;
		// every restart (reset, wake, enable) begins the wait from zero
		if (!main_run_q)
		begin
			main_cnt_d = '0;
			main_valid_d = 1'b0;
		end
		else if (main_osc_clk_i && !main_prev_q && !main_valid_q)
		begin
			if (main_cnt_q >= main_term)
				main_valid_d = 1'b1;
			else
				main_cnt_d = main_cnt_q + 1'b1;
		end
		if (!sub_run_q)
		begin
			sub_cnt_d = '0;
			sub_valid_d = 1'b0;
		end
		else if (sub_osc_clk_i && !sub_prev_q && !sub_valid_q)
		begin
			if (sub_cnt_q == clk_switch_pkg::SUB_TERM_256)
				sub_valid_d = 1'b1;
			else
				sub_cnt_d = sub_cnt_q + 1'b1;
		end
	end

	// oscillator registers
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			main_run_q <= 1'b1;
			sub_run_q <= 1'b0;
			main_prev_q <= 1'b0;
			sub_prev_q <= 1'b0;
			main_cnt_q <= '0;
			sub_cnt_q <= '0;
			main_valid_q <= 1'b0;
			sub_valid_q <= 1'b0;
		end
		else
		begin
			main_run_q <= main_run_d;
			sub_run_q <= sub_run_d;
			main_prev_q <= main_prev_d;
			sub_prev_q <= sub_prev_d;
			main_cnt_q <= main_cnt_d;
			sub_cnt_q <= sub_cnt_d;
			main_valid_q <= main_valid_d;
			sub_valid_q <= sub_valid_d;
		end
	end

	// ****************************************************************
	// system clock switch
	// ****************************************************************
	// a high phase always runs to its natural end; the handover happens
	// only with the output low and the new source low, so no pulse is cut
	always_comb
	begin
		target = clk_switch_pkg::src_t'(src_q[clk_switch_pkg::SRC_BIT]);
		tgt_valid = (target == clk_switch_pkg::SRC_SUB) ? sub_valid_q : main_valid_q;
		tgt_lvl = (target == clk_switch_pkg::SRC_SUB) ? sub_osc_clk_i : main_osc_clk_i;
		act_valid = (active_q == clk_switch_pkg::SRC_SUB) ? sub_valid_q : main_valid_q;
		act_lvl = (active_q == clk_switch_pkg::SRC_SUB) ? sub_osc_clk_i : main_osc_clk_i;
		active_d = active_q;
		sys_d = act_lvl && act_valid;
		if (!sys_q && target != active_q)
		begin
			sys_d = 1'b0;
			if (tgt_valid && !tgt_lvl)
				active_d = target;
		end
		core_run_d = act_valid && target == active_q;
	end

	// switch registers
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			active_q <= clk_switch_pkg::SRC_MAIN;
			sys_q <= 1'b0;
			core_run_q <= 1'b0;
		end
		else
		begin
			active_q <= active_d;
			sys_q <= sys_d;
			core_run_q <= core_run_d;
		end
	end

	// outputs, all straight from flip-flops
	assign wb_dat_o = dat_q;
	assign wb_ack_o = ack_q;
	assign main_osc_run_o = main_run_q;
	assign sub_osc_run_o = sub_run_q;
	assign sysclk_o = sys_q;
	assign sysclk_src_o = active_q;
	assign core_run_o = core_run_q;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_req;
		wb_cyc_i && wb_stb_i && !ack_q;
	endsequence
	sequence s_ack_pulse;
		ack_q ##1 !ack_q;
	endsequence

	property p_reset_state;
		$past(!rst_n_i) |-> active_q == clk_switch_pkg::SRC_MAIN && main_run_q &&
			ctl_q[clk_switch_pkg::MAIN_EN_BIT] && !core_run_q;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("bad reset state");

	property p_sleep_stop;
		sleep_i |=> !main_run_q && !sub_run_q ##1 !main_valid_q && !sub_valid_q;
	endproperty
	a_sleep_stop: assert property (p_sleep_stop) else $error("sleep left an osc running");

	property p_main_wait;
		$rose(main_valid_q) |-> $past(main_cnt_q) == $past(main_term);
	endproperty
	a_main_wait: assert property (p_main_wait) else $error("main valid early");

	property p_sub_wait;
		$rose(sub_valid_q) |-> $past(sub_cnt_q) == clk_switch_pkg::SUB_TERM_256;
	endproperty
	a_sub_wait: assert property (p_sub_wait) else $error("sub valid early");

	property p_main_kept;
		active_q == clk_switch_pkg::SRC_MAIN && !sleep_i |=> main_run_q;
	endproperty
	a_main_kept: assert property (p_main_kept) else $error("selected main stopped");

	property p_sub_kept;
		active_q == clk_switch_pkg::SRC_SUB && !sleep_i |=> sub_run_q;
	endproperty
	a_sub_kept: assert property (p_sub_kept) else $error("selected sub stopped");

	property p_clean_switch;
		active_q != $past(active_q) |-> !$past(sys_q) && !sys_q;
	endproperty
	a_clean_switch: assert property (p_clean_switch) else $error("switch during high");

	property p_halt_unready;
		!core_run_q && !sys_q |-> ##1 (!sys_q || act_valid);
	endproperty
	a_halt_unready: assert property (p_halt_unready) else $error("clock from unready osc");

	property p_core_hold;
		!main_valid_q && active_q == clk_switch_pkg::SRC_MAIN |=> !core_run_q;
	endproperty
	a_core_hold: assert property (p_core_hold) else $error("core ran before wait");

	property p_bus_ack;
		s_req |=> s_ack_pulse;
	endproperty
	a_bus_ack: assert property (p_bus_ack) else $error("ack timing wrong");

	property p_src_write;
		s_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i[31:2] == clk_switch_pkg::SRC_ADDR[31:2])
			|=> src_q[clk_switch_pkg::SRC_BIT] == $past(wb_dat_i[clk_switch_pkg::SRC_BIT]);
	endproperty
	a_src_write: assert property (p_src_write) else $error("source write lost");

endmodule : dual_oscillator_clock_switch

/* osc_pair_model.sv */
// behavioural main and sub oscillators feeding the clock switch.
// assumes the run requests are registered levels on core_clk_i.
`timescale 1ns/1ps

module osc_pair_model (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic main_run_i,
	input wire logic sub_run_i,
	output logic main_osc_clk_o,
	output logic sub_osc_clk_o
);
	logic main_d;
	logic [1:0] sub_q;
	logic [1:0] sub_d;

	// a stopped crystal rests low, so every restart begins from the low phase;
	// main rises every 2 core cycles, sub every 4, to keep the run short
	always_comb
	begin
		main_d = main_run_i ? ~main_osc_clk_o : 1'b0;
		sub_d = sub_run_i ? sub_q + 2'h1 : 2'h0;
	end

	always_ff @(posedge core_clk_i)
	begin
		main_osc_clk_o <= rst_n_i ? main_d : 1'b0;
		sub_q <= rst_n_i ? sub_d : 2'h0;
		sub_osc_clk_o <= rst_n_i ? sub_q[1] : 1'b0;
	end
endmodule : osc_pair_model

/* tb_dual_oscillator_clock_switch.sv */
// self-checking bench for the clock switch: registers, start-up waits,
// source switching and sleep. assumes the oscillator pair model beside it.
`timescale 1ns/1ps

module tb_dual_oscillator_clock_switch;
	logic clk, rst_n, slp, cyc, stb, we, mclk, sclk;
	logic ack, mrun, srun, sysclk, src, run;
	logic [31:0] adr, wdat, rd, dat_o;
	logic [3:0] sel;
	int n_fail = 0;
	int n_checks = 0;
	int cycles = 0;
	int t0;

	dual_oscillator_clock_switch dual_oscillator_clock_switch_inst (.core_clk_i(clk),
		.rst_n_i(rst_n), .sleep_i(slp), .main_osc_clk_i(mclk), .sub_osc_clk_i(sclk),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .main_osc_run_o(mrun),
		.sub_osc_run_o(srun), .sysclk_o(sysclk), .sysclk_src_o(src), .core_run_o(run));
	osc_pair_model osc_pair_model_inst (.core_clk_i(clk), .rst_n_i(rst_n),
		.main_run_i(mrun), .sub_run_i(srun), .main_osc_clk_o(mclk), .sub_osc_clk_o(sclk));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// the whole sequence needs about 9000 cycles; a hang ends the run
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_fail++;
			stop_test();
		end
	end

	// ****************************************************************
	// checks and bus cycles
	// ****************************************************************
	task chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk_val

	task chk_cnt(input string nm, input int lo, input int hi, input int got);
		n_checks++;
		if (got < lo || got > hi)
		begin
			n_fail++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask : chk_cnt

	// request held until ack is sampled high, released only after that edge
	task wb_xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do @(posedge clk); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb_xfer

	task wr(input logic [31:0] a, input logic [31:0] d);
		wb_xfer(1'b1, a, d, 4'hF);
	endtask : wr

	task rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
		wb_xfer(1'b0, a, 32'h00000000, 4'hF);
		chk_val(nm, exp, rd);
	endtask : rdc

	// core_run delay from t0; the system clock must stay low while halted.
	// two edges pass first: a source write that has just been acked only
	// reaches core_run one cycle later, so an early look sees the old level
	task wait_run(input string nm, input int lo, input int hi);
		int seen;
		seen = 0;
		repeat (2) @(posedge clk);
		while (run !== 1'b1 && cycles - t0 <= hi)
		begin
			@(posedge clk);
			if (cycles - t0 > 8 && cycles - t0 < lo - 8 && sysclk === 1'b1)
				seen++;
		end
		chk_cnt(nm, lo, hi, cycles - t0);
		chk_val("sysclk during halt", 32'h00000000, seen);
	endtask : wait_run

	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		{rst_n, slp, cyc, stb, we, adr, wdat, sel} = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t0 = cycles;
		chk_val("source after reset", 32'h0, src);
		chk_val("main run after reset", 32'h1, mrun);
		rdc("control reset", clk_switch_pkg::CTL_ADDR, 32'h01);
		rdc("source reset", clk_switch_pkg::SRC_ADDR, 32'h00);
		wait_run("start-up wait", 2040, 2064);
		rdc("unmapped read", 32'h00000010, 32'h0);
		wb_xfer(1'b1, clk_switch_pkg::CTL_ADDR, 32'h30, 4'h0);
		rdc("lane-off write", clk_switch_pkg::CTL_ADDR, 32'h01);
		// clearing the enable of the selected source must not stop it
		wr(clk_switch_pkg::CTL_ADDR, 32'h00);
		repeat (4) @(posedge clk);
		chk_val("selected main kept", 32'h1, mrun);
		wr(clk_switch_pkg::CTL_ADDR, 32'h03);
		t0 = cycles;
		wr(clk_switch_pkg::SRC_ADDR, 32'h01);
		wait_run("sub start halt", 1018, 1046);
		chk_val("active source", 32'h1, src);
		rdc("status", clk_switch_pkg::STAT_ADDR, 32'h0F);
		wr(clk_switch_pkg::CTL_ADDR, 32'h01);
		repeat (4) @(posedge clk);
		chk_val("selected sub kept", 32'h1, srun);
		// each wait code: stop main, restart it and switch back onto it
		for (int c = 3; c >= 0; c--)
		begin
			wr(clk_switch_pkg::CTL_ADDR, 32'h02 | (c << 4));
			repeat (4) @(posedge clk);
			chk_val("main stopped", 32'h0, mrun);
			wr(clk_switch_pkg::CTL_ADDR, 32'h03 | (c << 4));
			t0 = cycles;
			rdc("control", clk_switch_pkg::CTL_ADDR, 32'h03 | (c << 4));
			wr(clk_switch_pkg::SRC_ADDR, 32'h00);
			wait_run("main wait", (256 << (3 - c)) - 6, (256 << (3 - c)) + 14);
			wr(clk_switch_pkg::SRC_ADDR, 32'h01);
			t0 = cycles;
			wait_run("back to sub", 0, 12);
		end
		wr(clk_switch_pkg::SRC_ADDR, 32'h00);
		t0 = cycles;
		wait_run("to main", 0, 12);
		wr(clk_switch_pkg::CTL_ADDR, 32'h01);
		repeat (4) @(posedge clk);
		chk_val("sub stopped", 32'h0, srun);
		wr(clk_switch_pkg::CTL_ADDR, 32'h03);
		slp <= 1'b1;
		repeat (4) @(posedge clk);
		chk_val("sleep main", 32'h0, mrun);
		chk_val("sleep sub", 32'h0, srun);
		slp <= 1'b0;
		t0 = cycles;
		wait_run("wake wait", 2040, 2066);
		stop_test();
	end
endmodule : tb_dual_oscillator_clock_switch
